// file: rtl/msd_decoder.sv
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "msd_regs.svh"
module msd_decoder
    import msd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Avalon-MM slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Static options
    input  wire logic        ext_access_n,
    input  wire logic        rom_protect,
    input  wire logic        verify_req1,
    input  wire logic        verify_req2,
    // Code fetch side
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        code_read_move,
    input  wire logic        exec_from_rom,
    output logic             fetch_internal,
    output logic             code_read_blocked,
    output logic             verify1_en,
    output logic             verify2_en,
    // Internal data decode
    input  wire logic [7:0]  int_addr,
    input  wire logic        int_direct,
    output msd_iarea_e       int_area,
    output logic [1:0]       int_bank,
    // External data move
    input  msd_move_s        ext_data_move,
    output logic             move_done,
    output logic [7:0]       move_rdata,
    // External bus
    output msd_bus_s         bus,
    input  wire logic [7:0]  bus_rdata
);
    logic [7:0]  ext_ram_page_reg;
    logic [7:0]  port_two_latch;
    logic        ext_ram_disable;
    logic        ext_ram_strobe_show;
    logic [7:0]  extended_onchip_ram [0:1023];
    msd_move_e   state;
    msd_move_s   mv;
    logic        acc_cycle;
    logic        hit_ram;
    logic [15:0] eff_addr;
    logic [7:0]  ram_q;

    // Register access; one-cycle turnaround via acc_cycle
    assign waitrequest = (read | write) & ~acc_cycle;

    always_ff @(posedge clk) begin
        if (reset) begin
            acc_cycle <= 1'b0;
        end else begin
            acc_cycle <= (read | write) & ~acc_cycle;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ext_ram_page_reg <= `MSD_PAGE_RST;
            port_two_latch   <= `MSD_PORT2_RST;
        end else if (write && acc_cycle) begin
            if (address == `MSD_OFS_PAGE) begin
                ext_ram_page_reg <= writedata[7:0];
            end else if (address == `MSD_OFS_PORT2) begin
                port_two_latch   <= writedata[7:0];
                ext_ram_page_reg <= writedata[7:0];
            end
        end
    end

    // Asymmetric latch: software can only clear the disable bit
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_ram_disable     <= `MSD_DISABLE_RST;
            ext_ram_strobe_show <= `MSD_STROBE_RST;
        end else if (write && acc_cycle
                     && address == `MSD_OFS_SYSCTRL) begin
            ext_ram_strobe_show <= writedata[`MSD_BIT_STROBE];
            if (!writedata[`MSD_BIT_DISABLE]) begin
                ext_ram_disable <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            readdata <= 32'h0000_0000;
        end else if (read && !acc_cycle) begin
            if (address == `MSD_OFS_PAGE) begin
                readdata <= {24'h00_0000, ext_ram_page_reg};
            end else if (address == `MSD_OFS_PORT2) begin
                readdata <= {24'h00_0000, port_two_latch};
            end else if (address == `MSD_OFS_SYSCTRL) begin
                readdata <= {30'h0000_0000, ext_ram_strobe_show,
                             ext_ram_disable};
            end else if (address == `MSD_OFS_STATUS) begin
                readdata <= {28'h000_0000, rom_protect, ext_access_n,
                             state};
            end else begin
                readdata <= 32'h0000_0000;
            end
        end
    end

    // Code space decode
    always_comb begin
        fetch_internal    = fetch_valid && ext_access_n
                            && fetch_addr < `MSD_ROM_TOP;
        code_read_blocked = code_read_move && rom_protect
                            && !exec_from_rom
                            && fetch_addr < `MSD_ROM_TOP;
        verify1_en        = verify_req1 && !rom_protect;
        verify2_en        = verify_req2;
    end

    // Internal data memory areas
    always_comb begin
        int_bank = int_addr[4:3];
        if (int_addr < `MSD_LOW_RAM_TOP) begin
            int_area = MSD_IAREA_LOW;
        end else if (int_direct) begin
            int_area = MSD_IAREA_SFR;
        end else begin
            int_area = MSD_IAREA_UP;
        end
    end

    // Data move decode on the captured request
    always_comb begin
        if (mv.use_index) begin
            hit_ram  = !ext_ram_disable
                       && mv.pointer[15:8] >= `MSD_EXTENDED_ONCHIP_RAM_PAGE;
            eff_addr = hit_ram ? {ext_ram_page_reg, mv.index}
                               : {port_two_latch, mv.index};
        end else begin
            hit_ram  = !ext_ram_disable
                       && mv.pointer >= `MSD_EXTENDED_ONCHIP_RAM_BASE;
            eff_addr = mv.pointer;
        end
    end

    // Two-cycle move: commit the RAM write only in cycle 2
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= MSD_IDLE;
            mv    <= '0;
        end else begin
            case (state)
                MSD_IDLE: begin
                    if (ext_data_move.valid) begin
                        mv <= ext_data_move;
                        if (ext_data_move.use_index) begin
                            mv.pointer <= {ext_ram_page_reg,
                                           ext_data_move.index};
                        end
                        state <= MSD_CYC1;
                    end
                end
                MSD_CYC1: state <= MSD_CYC2;
                default:  state <= MSD_IDLE;
            endcase
        end
    end

    // RAM has no reset so contents survive it; aliasing past FBFF
    always_ff @(posedge clk) begin
        if (state == MSD_CYC2 && hit_ram && mv.write) begin
            extended_onchip_ram[eff_addr[9:0]] <= mv.wdata;
        end
        ram_q <= extended_onchip_ram[eff_addr[9:0]];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bus        <= '0;
            move_done  <= 1'b0;
            move_rdata <= 8'h00;
        end else begin
            move_done <= (state == MSD_CYC2);
            if (state == MSD_CYC1) begin
                bus.valid <= 1'b1;
                bus.ext   <= !hit_ram;
                bus.rd    <= !mv.write
                             && (!hit_ram || ext_ram_strobe_show);
                bus.wr    <= mv.write
                             && (!hit_ram || ext_ram_strobe_show);
                bus.addr  <= eff_addr;
                bus.wdata <= mv.wdata;
            end else if (state == MSD_CYC2) begin
                bus        <= '0;
                move_rdata <= bus.ext ? bus_rdata : ram_q;
            end
        end
    end

    // Register file
    chk_page_follows_p2: assert property (
        @(posedge clk) disable iff (reset)
        write && !waitrequest && address == `MSD_OFS_PORT2
        |=> ext_ram_page_reg == $past(writedata[7:0]))
        else $error("page did not follow port two");
    chk_p2_written: assert property (
        @(posedge clk) disable iff (reset)
        write && !waitrequest && address == `MSD_OFS_PORT2
        |=> port_two_latch == $past(writedata[7:0]))
        else $error("port two latch not written");
    chk_page_written: assert property (
        @(posedge clk) disable iff (reset)
        write && !waitrequest && address == `MSD_OFS_PAGE
        |=> ext_ram_page_reg == $past(writedata[7:0]))
        else $error("page register not written");
    chk_page_rst: assert property (
        @(posedge clk) reset |=> ext_ram_page_reg == `MSD_PAGE_RST)
        else $error("page register not cleared by reset");
    chk_wait_first: assert property (
        @(posedge clk) disable iff (reset)
        (read || write) && !acc_cycle |-> waitrequest)
        else $error("request answered without wait state");
    chk_wait_release: assert property (
        @(posedge clk) disable iff (reset)
        (read || write) && !waitrequest |=> !acc_cycle)
        else $error("turnaround flag stuck");
    // Disable bit and strobe control
    chk_disable_rst: assert property (
        @(posedge clk) reset |=> ext_ram_disable)
        else $error("reset did not disable ram");
    chk_disable_sticky: assert property (
        @(posedge clk) disable iff (reset)
        !ext_ram_disable |=> !ext_ram_disable)
        else $error("disable bit set by software");
    chk_strobe_rst: assert property (
        @(posedge clk) reset |=> !ext_ram_strobe_show)
        else $error("strobe show not cleared by reset");
    // Data move decode and bus; decode used the previous cycle's controls
    chk_ram_no_ext: assert property (
        @(posedge clk) disable iff (reset)
        bus.valid && !$past(ext_ram_disable) && !mv.use_index
        && bus.addr >= `MSD_EXTENDED_ONCHIP_RAM_BASE |-> !bus.ext)
        else $error("external access in ram range");
    chk_disabled_ext: assert property (
        @(posedge clk) disable iff (reset)
        bus.valid && $past(ext_ram_disable) |-> bus.ext)
        else $error("ram used while disabled");
    chk_low_ptr_ext: assert property (
        @(posedge clk) disable iff (reset)
        bus.valid && !mv.use_index && bus.addr < `MSD_EXTENDED_ONCHIP_RAM_BASE
        |-> bus.ext)
        else $error("low pointer did not go external");
    chk_low_page_p2: assert property (
        @(posedge clk) disable iff (reset)
        state == MSD_CYC1 && mv.use_index && !hit_ram
        |=> bus.addr[15:8] == $past(port_two_latch))
        else $error("upper byte not from port two");
    chk_page_ram: assert property (
        @(posedge clk) disable iff (reset)
        state == MSD_CYC1 && mv.use_index && !ext_ram_disable
        && mv.pointer[15:8] >= `MSD_EXTENDED_ONCHIP_RAM_PAGE
        |=> !bus.ext && bus.addr[7:0] == $past(mv.index))
        else $error("page access missed ram");
    chk_ptr_addr: assert property (
        @(posedge clk) disable iff (reset)
        state == MSD_CYC1 && !mv.use_index
        |=> bus.addr == $past(mv.pointer))
        else $error("pointer address not passed on");
    chk_take_move: assert property (
        @(posedge clk) disable iff (reset)
        state == MSD_IDLE && ext_data_move.valid |=> state == MSD_CYC1)
        else $error("move request not taken");
    chk_move_len: assert property (
        @(posedge clk) disable iff (reset)
        state == MSD_CYC1 |=> state == MSD_CYC2 ##1 move_done)
        else $error("move not two cycles");
    chk_reset_cancel: assert property (
        @(posedge clk) reset |=> state == MSD_IDLE && !bus.valid)
        else $error("reset did not cancel move");
    chk_bus_in_cyc2: assert property (
        @(posedge clk) disable iff (reset)
        bus.valid |-> state == MSD_CYC2)
        else $error("bus cycle outside second cycle");
    chk_done_pulse: assert property (
        @(posedge clk) disable iff (reset)
        move_done |=> !move_done)
        else $error("move done longer than one cycle");
    chk_ext_one_strobe: assert property (
        @(posedge clk) disable iff (reset)
        bus.valid && bus.ext |-> bus.rd != bus.wr)
        else $error("external access without one strobe");
    chk_strobe_hide: assert property (
        @(posedge clk) disable iff (reset)
        bus.valid && !bus.ext && !$past(ext_ram_strobe_show)
        |-> !bus.rd && !bus.wr)
        else $error("strobe shown on ram access");
    chk_strobe_show: assert property (
        @(posedge clk) disable iff (reset)
        bus.valid && !bus.ext && $past(ext_ram_strobe_show)
        |-> bus.rd != bus.wr)
        else $error("strobe hidden on ram access");
    // Code space and verification
    chk_fetch_high_ext: assert property (
        @(posedge clk) fetch_addr >= `MSD_ROM_TOP |-> !fetch_internal)
        else $error("high fetch went internal");
    chk_fetch_pin_low: assert property (
        @(posedge clk) !ext_access_n |-> !fetch_internal)
        else $error("fetch internal with access pin low");
    chk_fetch_rom: assert property (
        @(posedge clk) fetch_valid && ext_access_n
        && fetch_addr < `MSD_ROM_TOP |-> fetch_internal)
        else $error("low fetch did not use rom");
    chk_protect_block: assert property (
        @(posedge clk) rom_protect && code_read_move && !exec_from_rom
        && fetch_addr < `MSD_ROM_TOP |-> code_read_blocked)
        else $error("protected rom read allowed");
    chk_rom_exec_free: assert property (
        @(posedge clk) exec_from_rom |-> !code_read_blocked)
        else $error("code from rom was blocked");
    chk_unprotected: assert property (
        @(posedge clk) !rom_protect |-> !code_read_blocked)
        else $error("read blocked without protection");
    chk_verify_mode: assert property (
        @(posedge clk) rom_protect |-> !verify1_en)
        else $error("verify mode 1 under protection");
    chk_verify_free: assert property (
        @(posedge clk) !rom_protect && verify_req1 |-> verify1_en)
        else $error("verify mode 1 refused");
    chk_verify_two: assert property (
        @(posedge clk) verify_req2 |-> verify2_en)
        else $error("verify mode 2 refused");
    // Internal data areas
    chk_area_low: assert property (
        @(posedge clk) int_addr < `MSD_LOW_RAM_TOP
        |-> int_area == MSD_IAREA_LOW)
        else $error("low ram not decoded");
    chk_area_sfr: assert property (
        @(posedge clk) int_addr >= `MSD_LOW_RAM_TOP && int_direct
        |-> int_area == MSD_IAREA_SFR)
        else $error("sfr area not decoded");
    chk_area_up: assert property (
        @(posedge clk) int_addr >= `MSD_LOW_RAM_TOP && !int_direct
        |-> int_area == MSD_IAREA_UP)
        else $error("upper ram not decoded");
endmodule

// file: rtl/msd_pkg.sv
package msd_pkg;
    typedef enum logic [1:0] {
        MSD_IDLE   = 2'b00,
        MSD_CYC1   = 2'b01,
        MSD_CYC2   = 2'b10
    } msd_move_e;

    typedef enum logic [1:0] {
        MSD_IAREA_LOW = 2'b00,
        MSD_IAREA_UP  = 2'b01,
        MSD_IAREA_SFR = 2'b10
    } msd_iarea_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        use_index;
        logic [15:0] pointer;
        logic [7:0]  index;
        logic [7:0]  wdata;
    } msd_move_s;

    typedef struct packed {
        logic        valid;
        logic        ext;
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } msd_bus_s;
endpackage

// file: rtl/msd_regs.svh
`ifndef MSD_REGS_SVH
`define MSD_REGS_SVH

// Avalon word offsets
`define MSD_OFS_PAGE      8'h91
`define MSD_OFS_SYSCTRL   8'hB1
`define MSD_OFS_PORT2     8'hA0
`define MSD_OFS_STATUS    8'hC0

`define MSD_BIT_DISABLE   0
`define MSD_BIT_STROBE    1

`define MSD_PAGE_RST      8'h00
`define MSD_SYSCTRL_RST   2'b01
`define MSD_PORT2_RST     8'hFF
`define MSD_DISABLE_RST   1'b1
`define MSD_STROBE_RST    1'b0

`define MSD_EXTENDED_ONCHIP_RAM_BASE     16'hF800
`define MSD_EXTENDED_ONCHIP_RAM_PAGE     8'hF8
`define MSD_ROM_TOP       16'h8000
`define MSD_LOW_RAM_TOP   8'h80
`define MSD_BANK_SIZE     8'h08
`endif

// file: verification/msd_ext_mem.sv
`timescale 1ns/1ps
module msd_ext_mem
    import msd_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Bus from the decoder
    input  msd_bus_s        bus,
    output logic      [7:0] bus_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] idle;
    // Known pattern so untouched cells can be checked
    initial begin
        idle = 8'h00;
        for (int i = 0; i < 65536; i++)
            mem[i] = i[7:0] ^ i[15:8];
    end
    // Released bus toggles, never shows stale data
    always @(posedge clk) idle <= ~idle;
    always_comb begin
        if (bus.valid && bus.ext && bus.rd)
            bus_rdata = mem[bus.addr];
        else
            bus_rdata = idle;
    end
    always @(posedge clk) begin
        if (bus.valid && bus.ext && bus.wr)
            mem[bus.addr] <= bus.wdata;
    end
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
    import msd_pkg::*;
    logic        clk, reset, read, write, waitrequest, ea_n, prot;
    logic        v1, v2, f_int, blk, crm, from_rom, move_done, idir;
    logic [7:0]  address, bus_rdata, move_rdata, md, ia;
    logic [2:0]  bs;
    logic [1:0]  ib;
    msd_iarea_e  iarea;
    logic [31:0] writedata, readdata, rv;
    logic [15:0] faddr;
    msd_move_s   mv;
    msd_bus_s    bus;
    int          err_total, cmp_count;

    msd_decoder dut (.clk, .reset, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .ext_access_n(ea_n), .rom_protect(prot),
        .verify_req1(1'b1), .verify_req2(1'b1), .fetch_valid(1'b1),
        .fetch_addr(faddr), .code_read_move(crm), .exec_from_rom(from_rom),
        .fetch_internal(f_int), .code_read_blocked(blk), .verify1_en(v1),
        .verify2_en(v2), .int_addr(ia), .int_direct(idir),
        .int_area(iarea), .int_bank(ib), .ext_data_move(mv), .move_done,
        .move_rdata, .bus, .bus_rdata);
    msd_ext_mem ext (.clk, .bus, .bus_rdata);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic bounded(input int n);
        if (n >= 40) begin
            err_total++;
            close_out();
        end
    endtask

    // Avalon access; request held until waitrequest seen low
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        bounded(n);
        rv = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    // Data move; index mode uses p[7:0] as index
    task automatic move(input logic w, input logic idx,
                        input logic [15:0] p, input logic [7:0] d);
        int n;
        n = 0;
        bs = 3'b000;
        mv <= '{1'b1, w, idx, p, p[7:0], d};
        @(posedge clk);
        mv.valid <= 1'b0;
        do begin
            @(negedge clk);
            n++;
            if (bus.valid)
                bs = {bus.ext, bus.rd, bus.wr};
        end while (move_done !== 1'b1 && n < 40);
        bounded(n);
        md = move_rdata;
        @(posedge clk);
    endtask

    // Reset seen in cycle k of a RAM write, then RAM enabled again
    task automatic rst_in(input int k, input logic [7:0] d);
        mv <= '{1'b1, 1'b1, 1'b0, 16'hF800, 8'h00, d};
        @(posedge clk);
        mv.valid <= 1'b0;
        repeat (k - 1) @(posedge clk);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        acc(1'b1, 8'hB1, 32'h0000_0000);
        move(1'b0, 1'b0, 16'hF800, 8'h00);
    endtask

    initial begin
        {read, write, address, writedata, mv} = '0;
        {ea_n, prot, crm, from_rom, faddr, ia, idir} = '0;
        err_total = 0;
        cmp_count = 0;
        reset = 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        acc(1'b0, 8'h91, 32'h0000_0000);
        check(rv, 32'h0000_0000);
        acc(1'b0, 8'hB1, 32'h0000_0000);
        check(rv & 32'h0000_0003, 32'h0000_0001);
        acc(1'b0, 8'h10, 32'h0000_0000);
        check(rv, 32'h0000_0000);
        acc(1'b1, 8'h91, 32'h0000_00F8);
        acc(1'b0, 8'h91, 32'h0000_0000);
        check(rv, 32'h0000_00F8);
        acc(1'b1, 8'hA0, 32'h0000_0012);
        acc(1'b0, 8'h91, 32'h0000_0000);
        check(rv, 32'h0000_0012);
        $display("register test done");
        move(1'b1, 1'b0, 16'hF800, 8'h5A);
        check(ext.mem[16'hF800], 8'h5A);
        move(1'b1, 1'b1, 16'h1234, 8'h99);
        check(ext.mem[16'h1234], 8'h99);
        acc(1'b1, 8'hB1, 32'h0000_0000);
        move(1'b1, 1'b0, 16'hF800, 8'hA5);
        check(bs, 3'b000);
        move(1'b0, 1'b0, 16'hF800, 8'h00);
        check(md, 8'hA5);
        check(ext.mem[16'hF800], 8'h5A);
        move(1'b1, 1'b0, 16'hFFFF, 8'h3C);
        check(ext.mem[16'hFFFF], 8'h00);
        move(1'b1, 1'b0, 16'hF7FF, 8'h77);
        move(1'b0, 1'b0, 16'hF7FF, 8'h00);
        check(md, 8'h77);
        acc(1'b1, 8'hB1, 32'h0000_0002);
        move(1'b1, 1'b0, 16'hF820, 8'h44);
        check(bs, 3'b001);
        move(1'b0, 1'b0, 16'hF820, 8'h00);
        check({bs, md}, {3'b010, 8'h44});
        acc(1'b1, 8'hB1, 32'h0000_0001);
        acc(1'b0, 8'hB1, 32'h0000_0000);
        check(rv & 32'h0000_0001, 32'h0000_0000);
        acc(1'b1, 8'h91, 32'h0000_00F8);
        move(1'b1, 1'b1, 16'h1210, 8'h66);
        check(ext.mem[16'h1210], 8'h02);
        move(1'b0, 1'b0, 16'hF810, 8'h00);
        check(md, 8'h66);
        $display("move test done");
        rst_in(1, 8'h11);
        check(md, 8'hA5);
        rst_in(2, 8'h22);
        check(md, 8'h22);
        $display("reset test done");
        ea_n <= 1'b1;
        prot <= 1'b1;
        crm <= 1'b1;
        faddr <= 16'h7FFF;
        ia <= 8'h18;
        @(negedge clk);
        check(f_int, 1'b1);
        check(blk, 1'b1);
        check({v1, v2}, 2'b01);
        check({iarea, ib}, {MSD_IAREA_LOW, 2'b11});
        @(posedge clk);
        faddr <= 16'h8000;
        from_rom <= 1'b1;
        prot <= 1'b0;
        ia <= 8'h90;
        idir <= 1'b1;
        @(negedge clk);
        check({f_int, blk}, 2'b00);
        check({v1, v2}, 2'b11);
        check(iarea, MSD_IAREA_SFR);
        $display("fetch test done");
        close_out();
    end
endmodule
